// >>> hw/cpc_codec_ctrl.sv
// Operation
// - rx path bit bypasses smoothing filter
// - three-bit rx trim attenuation, 0 to 7 dB
// - rx path bit powers down power amp
// - rx path bit powers down aux driver
// - three-bit sidetone gain select field
// - tone generator active disables decoder
// - tone feeds rx gain, optionally encoder
// - tone off at 64k unless loopback
// - reset pin low powers whole device down
// - analog and digital power down separately
// - powered down outputs go high impedance
// - pin rising edge resets coder state
// - data out stays off two syncs
// - reset default: duplex voice, pump on
// - prescaler locks to tx frame sync
// - main bit selects rx bit clock direct
// - direct mode: tx bit clock times both
// - companding selectable, same serial timing
// - frame sync times word and conversions
// - data out driven from sync rise onward, long sync only
// - sync length selects coding rate
// - long when high two bit-clock falls
`include "cpc_regs.svh"

module cpc_codec_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire cpc_pkg::cpc_axi_req_s s_axi_req,
  output cpc_pkg::cpc_axi_rsp_s s_axi_rsp,
  input wire logic powerdown_reset_n,
  input wire logic tx_frame_sync,
  input wire logic tx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic rx_bit_clock,
  input wire logic serial_data_in,
  input wire logic [7:0] tx_word,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  output logic control_port_tx_oe,
  output logic [7:0] rx_word,
  output logic rx_word_valid,
  output cpc_pkg::cpc_rate_e rx_rate,
  output cpc_pkg::cpc_rate_e tx_rate,
  output logic seq_clk_tick,
  output cpc_pkg::cpc_ctrl_s ctrl
);

  cpc_pkg::cpc_top_st_s st_ff;
  cpc_pkg::cpc_top_st_s nxt_st;
  cpc_pkg::cpc_pins_s pins;
  cpc_pkg::cpc_sel_e wsel;
  cpc_pkg::cpc_sel_e rsel;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic dig_down;
  logic analog_up;
  logic tone_on;
  logic psc_locked;
  logic rx_fall;
  logic [7:0] rd_val;
  logic [3:0] sent_n;

  function automatic cpc_pkg::cpc_sel_e addr_sel(input logic [7:0] a);
    cpc_pkg::cpc_sel_e s;
    unique case (a)
      `CPC_MAIN_OFS: s = cpc_pkg::SEL_MAIN;
      `CPC_TXG_OFS: s = cpc_pkg::SEL_TXG;
      `CPC_RXP_OFS: s = cpc_pkg::SEL_RXP;
      `CPC_TONEA_OFS: s = cpc_pkg::SEL_TONEA;
      `CPC_TONEB_OFS: s = cpc_pkg::SEL_TONEB;
      `CPC_TONED_OFS: s = cpc_pkg::SEL_TONED;
      `CPC_STAT_OFS: s = cpc_pkg::SEL_STAT;
      default: s = cpc_pkg::SEL_NONE;
    endcase
    return s;
  endfunction : addr_sel

  // count of bit-clock falls under frame sync to coding rate
  function automatic cpc_pkg::cpc_rate_e len_to_rate(
    input logic [3:0] n,
    input cpc_pkg::cpc_rate_e prev
  );
    cpc_pkg::cpc_rate_e r;
    unique case (n)
      `CPC_LEN_16K: r = cpc_pkg::RATE_16K;
      `CPC_LEN_24K: r = cpc_pkg::RATE_24K;
      `CPC_LEN_32K: r = cpc_pkg::RATE_32K;
      `CPC_LEN_64K: r = cpc_pkg::RATE_64K;
      default: r = prev;
    endcase
    return r;
  endfunction : len_to_rate

  function automatic logic [3:0] rate_to_len(input cpc_pkg::cpc_rate_e r);
    logic [3:0] n;
    unique case (r)
      cpc_pkg::RATE_16K: n = `CPC_LEN_16K;
      cpc_pkg::RATE_24K: n = `CPC_LEN_24K;
      cpc_pkg::RATE_32K: n = `CPC_LEN_32K;
      cpc_pkg::RATE_64K: n = `CPC_LEN_64K;
    endcase
    return n;
  endfunction : rate_to_len

  // register defaults, applied by bus reset and by the reset pin
  function automatic cpc_pkg::cpc_top_st_s reg_defaults(
    input cpc_pkg::cpc_top_st_s s
  );
    cpc_pkg::cpc_top_st_s o;
    o = s;
    o.main_reg = `CPC_MAIN_RST;
    o.txg_reg = `CPC_TXG_RST;
    o.rxp_reg = `CPC_RXP_RST;
    o.tonea_reg = `CPC_TONE_RST;
    o.toneb_reg = `CPC_TONE_RST;
    o.toned_reg = `CPC_TONE_RST;
    return o;
  endfunction : reg_defaults

  cpc_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .tx_frame_sync(tx_frame_sync),
    .tx_bit_clock(tx_bit_clock),
    .rx_frame_sync(rx_frame_sync),
    .rx_bit_clock(rx_bit_clock),
    .serial_data_in(serial_data_in),
    .pins(pins)
  );

  cpc_prescaler u_psc (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(analog_up),
    .direct_sel(st_ff.main_reg[`CPC_MAIN_DIRECT]),
    .fs_rise(pins.tx_fs_rise),
    .rx_bclk_rise(pins.rx_bclk_rise),
    .seq_tick(seq_clk_tick),
    .locked(psc_locked)
  );

  assign dig_down = ~powerdown_reset_n | st_ff.main_reg[`CPC_MAIN_DPD];
  assign analog_up = powerdown_reset_n & ~st_ff.main_reg[`CPC_MAIN_APD];
  assign tone_on = st_ff.toned_reg[`CPC_TONED_EN] & ~dig_down &
                   ((st_ff.tx_rate != cpc_pkg::RATE_64K) |
                    st_ff.main_reg[`CPC_MAIN_LOOP]);
  // in direct mode the receive word is clocked by the tx bit clock
  assign rx_fall = st_ff.main_reg[`CPC_MAIN_DIRECT] ? pins.tx_bclk_fall :
                   pins.rx_bclk_fall;
  assign wsel = addr_sel(st_ff.awaddr);
  assign rsel = addr_sel(s_axi_req.araddr);
  assign sent_n = st_ff.tx_sent + 4'h1;

  assign s_axi_rsp.awready = ~st_ff.aw_held & ~st_ff.bvalid;
  assign s_axi_rsp.wready = ~st_ff.w_held & ~st_ff.bvalid;
  assign s_axi_rsp.bvalid = st_ff.bvalid;
  assign s_axi_rsp.bresp = st_ff.bresp;
  assign s_axi_rsp.arready = ~st_ff.rvalid;
  assign s_axi_rsp.rvalid = st_ff.rvalid;
  assign s_axi_rsp.rdata = {24'h0, st_ff.rdata};
  assign s_axi_rsp.rresp = st_ff.rresp;
  assign aw_take = s_axi_req.awvalid & s_axi_rsp.awready;
  assign w_take = s_axi_req.wvalid & s_axi_rsp.wready;
  assign ar_take = s_axi_req.arvalid & s_axi_rsp.arready;

  always_comb begin
    unique case (rsel)
      cpc_pkg::SEL_MAIN: rd_val = st_ff.main_reg;
      cpc_pkg::SEL_TXG: rd_val = st_ff.txg_reg;
      cpc_pkg::SEL_RXP: rd_val = st_ff.rxp_reg;
      cpc_pkg::SEL_TONEA: rd_val = st_ff.tonea_reg;
      cpc_pkg::SEL_TONEB: rd_val = st_ff.toneb_reg;
      cpc_pkg::SEL_TONED: rd_val = st_ff.toned_reg;
      cpc_pkg::SEL_STAT: rd_val = {psc_locked, tone_on, st_ff.long_mode,
                                   st_ff.pwr == cpc_pkg::PWR_ON,
                                   st_ff.tx_rate, st_ff.rx_rate};
      cpc_pkg::SEL_NONE: rd_val = 8'h00;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.coder_rst = 1'h0;
    nxt_st.rx_valid = 1'h0;

    // write channel: address and data in either order, response after both
    if (st_ff.bvalid && s_axi_req.bready) begin
      nxt_st.bvalid = 1'h0;
    end
    if (aw_take) begin
      nxt_st.aw_held = 1'h1;
      nxt_st.awaddr = s_axi_req.awaddr;
    end
    if (w_take) begin
      nxt_st.w_held = 1'h1;
      nxt_st.wdata = s_axi_req.wdata[7:0];
      nxt_st.wstrb0 = s_axi_req.wstrb[0];
    end
    if (st_ff.aw_held && st_ff.w_held) begin
      nxt_st.aw_held = 1'h0;
      nxt_st.w_held = 1'h0;
      nxt_st.bvalid = 1'h1;
      nxt_st.bresp = (wsel == cpc_pkg::SEL_NONE) ? `CPC_RESP_SLVERR :
                     `CPC_RESP_OKAY;
      if (st_ff.wstrb0) begin
        unique case (wsel)
          cpc_pkg::SEL_MAIN: nxt_st.main_reg = st_ff.wdata;
          cpc_pkg::SEL_TXG: nxt_st.txg_reg = st_ff.wdata;
          cpc_pkg::SEL_RXP: nxt_st.rxp_reg = st_ff.wdata;
          cpc_pkg::SEL_TONEA: nxt_st.tonea_reg = st_ff.wdata;
          cpc_pkg::SEL_TONEB: nxt_st.toneb_reg = st_ff.wdata;
          cpc_pkg::SEL_TONED: nxt_st.toned_reg = st_ff.wdata;
          cpc_pkg::SEL_STAT, cpc_pkg::SEL_NONE: begin
          end
        endcase
      end
    end

    // read channel
    if (st_ff.rvalid && s_axi_req.rready) begin
      nxt_st.rvalid = 1'h0;
    end
    if (ar_take) begin
      nxt_st.rvalid = 1'h1;
      nxt_st.rdata = rd_val;
      nxt_st.rresp = (rsel == cpc_pkg::SEL_NONE) ? `CPC_RESP_SLVERR :
                     `CPC_RESP_OKAY;
    end

    // power sequencing
    nxt_st.pin_q = powerdown_reset_n;
    if (powerdown_reset_n && !st_ff.pin_q) begin
      nxt_st.coder_rst = 1'h1;
    end
    unique case (st_ff.pwr)
      cpc_pkg::PWR_OFF: begin
        if (!dig_down) begin
          nxt_st.pwr = cpc_pkg::PWR_WAIT;
          nxt_st.fs_seen = 2'h0;
        end
      end
      cpc_pkg::PWR_WAIT: begin
        if (dig_down) begin
          nxt_st.pwr = cpc_pkg::PWR_OFF;
        end else if (pins.tx_fs_fall) begin
          // data out may drive only after whole sync pulses have passed
          nxt_st.fs_seen = st_ff.fs_seen + 2'h1;
          if (nxt_st.fs_seen == `CPC_DT_WAIT_FS) begin
            nxt_st.pwr = cpc_pkg::PWR_ON;
          end
        end
      end
      cpc_pkg::PWR_ON: begin
        if (dig_down) begin
          nxt_st.pwr = cpc_pkg::PWR_OFF;
        end
      end
      default: nxt_st.pwr = cpc_pkg::PWR_OFF;
    endcase

    // transmit framing and data output
    if (pins.tx_fs && pins.tx_bclk_fall &&
        st_ff.tx_falls != `CPC_LEN_MAX) begin
      nxt_st.tx_falls = st_ff.tx_falls + 4'h1;
    end
    if (pins.tx_fs_rise) begin
      nxt_st.tx_falls = 4'h0;
      nxt_st.tx_sh = tx_word;
      nxt_st.tx_sent = 4'h0;
      if (st_ff.pwr == cpc_pkg::PWR_ON && st_ff.long_mode) begin
        nxt_st.dt_oe = 1'h1;
        nxt_st.dt_bit = tx_word[7];
      end
    end else if (st_ff.dt_oe) begin
      if (pins.tx_bclk_fall) begin
        nxt_st.tx_sent = sent_n;
        // stop half a bit early, but never while the sync is still high
        if (sent_n >= rate_to_len(st_ff.tx_rate) && !pins.tx_fs) begin
          nxt_st.dt_oe = 1'h0;
        end
      end
      if (pins.tx_bclk_rise && st_ff.tx_sent != 4'h0) begin
        nxt_st.tx_sh = {st_ff.tx_sh[6:0], 1'h0};
        nxt_st.dt_bit = st_ff.tx_sh[6];
      end
      // a short sync ends the drive too: the bit clock may stop after it
      if (pins.tx_fs_fall &&
          (st_ff.tx_sent >= rate_to_len(st_ff.tx_rate) ||
           st_ff.tx_falls < `CPC_LONG_FALLS)) begin
        nxt_st.dt_oe = 1'h0;
      end
    end
    if (pins.tx_fs_fall) begin
      nxt_st.long_mode = st_ff.tx_falls >= `CPC_LONG_FALLS;
      if (st_ff.tx_falls >= `CPC_LONG_FALLS) begin
        nxt_st.tx_rate = len_to_rate(st_ff.tx_falls, st_ff.tx_rate);
      end
    end
    if (st_ff.pwr != cpc_pkg::PWR_ON || dig_down) begin
      nxt_st.dt_oe = 1'h0;
    end

    // receive word capture, msb first on falling bit clock
    if (!dig_down) begin
      if (pins.rx_fs && rx_fall) begin
        nxt_st.rx_sh = {st_ff.rx_sh[6:0], pins.data_in};
        if (st_ff.rx_cnt != `CPC_LEN_MAX) begin
          nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
        end
      end
      if (pins.rx_fs_fall) begin
        nxt_st.rx_word = st_ff.rx_sh;
        nxt_st.rx_rate = len_to_rate(st_ff.rx_cnt, st_ff.rx_rate);
        nxt_st.rx_valid = 1'h1;
        nxt_st.rx_cnt = 4'h0;
      end
    end

    // reset pin low returns the control registers to their defaults
    if (!powerdown_reset_n) begin
      nxt_st = reg_defaults(nxt_st);
    end
    if (!aresetn) begin
      nxt_st = reg_defaults('0);
      nxt_st.long_mode = 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  assign serial_data_out = st_ff.dt_bit;
  assign serial_data_out_oe = st_ff.dt_oe;
  assign control_port_tx_oe = ~dig_down;
  assign rx_word = st_ff.rx_word;
  assign rx_word_valid = st_ff.rx_valid;
  assign rx_rate = st_ff.rx_rate;
  assign tx_rate = st_ff.tx_rate;

  always_comb begin
    ctrl.analog_oe = analog_up;
    ctrl.filter_bypass = st_ff.rxp_reg[`CPC_RXP_BYP];
    ctrl.rx_trim_atten = st_ff.rxp_reg[`CPC_TRIM_HI:`CPC_TRIM_LO];
    ctrl.tx_trim_gain = st_ff.txg_reg[`CPC_TRIM_HI:`CPC_TRIM_LO];
    ctrl.pa_enable = analog_up & ~st_ff.rxp_reg[`CPC_RXP_PAPD];
    ctrl.aux_enable = analog_up & ~st_ff.rxp_reg[`CPC_RXP_AXPD];
    ctrl.sidetone_code = st_ff.txg_reg[`CPC_ST_HI:`CPC_ST_LO];
    ctrl.a_law = st_ff.main_reg[`CPC_MAIN_ALAW];
    ctrl.charge_pump_en = analog_up &
                          ~st_ff.main_reg[`CPC_MAIN_CPOFF];
    ctrl.analog_loopback = st_ff.main_reg[`CPC_MAIN_LOOP];
    ctrl.io_mode = st_ff.main_reg[`CPC_MAIN_IO_HI:`CPC_MAIN_IO_LO];
    ctrl.direct_seq_clk = st_ff.main_reg[`CPC_MAIN_DIRECT];
    ctrl.tone_setting_a = st_ff.tonea_reg;
    ctrl.tone_setting_b = st_ff.toneb_reg;
    ctrl.tone_rate_delay = st_ff.toned_reg[`CPC_TONED_DLY];
    ctrl.tone_active = tone_on;
    ctrl.decoder_enable = ~dig_down & ~tone_on;
    ctrl.tone_to_rx_gain = tone_on;
    ctrl.tone_to_encoder = tone_on & st_ff.toned_reg[`CPC_TONED_ENC];
    ctrl.coder_reset = st_ff.coder_rst;
    ctrl.conv_strobe = pins.tx_fs_rise & ~dig_down;
  end

endmodule : cpc_codec_ctrl

// >>> shared/cpc_regs.svh
`ifndef CPC_REGS_SVH
`define CPC_REGS_SVH

// register byte offsets
`define CPC_MAIN_OFS 8'h00
`define CPC_TXG_OFS 8'h04
`define CPC_RXP_OFS 8'h08
`define CPC_TONEA_OFS 8'h10
`define CPC_TONEB_OFS 8'h14
`define CPC_TONED_OFS 8'h1c
`define CPC_STAT_OFS 8'h20

// reset values
`define CPC_MAIN_RST 8'h00
`define CPC_TXG_RST 8'h70
`define CPC_RXP_RST 8'h00
`define CPC_TONE_RST 8'h00

// main_control_reg fields
`define CPC_MAIN_APD 0
`define CPC_MAIN_DPD 1
`define CPC_MAIN_ALAW 2
`define CPC_MAIN_IO_LO 3
`define CPC_MAIN_IO_HI 4
`define CPC_MAIN_LOOP 5
`define CPC_MAIN_CPOFF 6
`define CPC_MAIN_DIRECT 7

// tx_gain_sidetone_reg and rx_path_control_reg fields
`define CPC_TRIM_LO 0
`define CPC_TRIM_HI 2
`define CPC_ST_LO 4
`define CPC_ST_HI 6
`define CPC_RXP_BYP 4
`define CPC_RXP_PAPD 5
`define CPC_RXP_AXPD 6

// tone_delay_control_reg fields
`define CPC_TONED_EN 0
`define CPC_TONED_ENC 1
`define CPC_TONED_DLY 5

// status register fields
`define CPC_STAT_LOCK 7
`define CPC_STAT_TONE 6
`define CPC_STAT_LONG 5
`define CPC_STAT_ON 4

// synchronised pin positions
`define CPC_PIN_TXFS 0
`define CPC_PIN_TXCK 1
`define CPC_PIN_RXFS 2
`define CPC_PIN_RXCK 3
`define CPC_PIN_DIN 4

// frame sync lengths in bit clocks; CPC_DT_WAIT_FS counts frame sync pulses
`define CPC_LEN_16K 4'h2
`define CPC_LEN_24K 4'h3
`define CPC_LEN_32K 4'h4
`define CPC_LEN_64K 4'h8
`define CPC_LEN_MAX 4'hf
`define CPC_LONG_FALLS 4'h2
`define CPC_DT_WAIT_FS 2'h2

// sequencing ticks per frame as a shift: 32 per frame
`define CPC_PER_SHIFT 5
`define CPC_PER_MAX 16'hffff

`define CPC_RESP_OKAY 2'h0
`define CPC_RESP_SLVERR 2'h2

`endif

// >>> shared/cpc_pkg.sv
package cpc_pkg;

  typedef enum logic [1:0] {
    RATE_16K = 2'b00,
    RATE_24K = 2'b01,
    RATE_32K = 2'b10,
    RATE_64K = 2'b11
  } cpc_rate_e;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_ON = 2'b10
  } cpc_pwr_e;

  typedef enum logic [2:0] {
    SEL_MAIN = 3'b000,
    SEL_TXG = 3'b001,
    SEL_RXP = 3'b010,
    SEL_TONEA = 3'b011,
    SEL_TONEB = 3'b100,
    SEL_TONED = 3'b101,
    SEL_STAT = 3'b110,
    SEL_NONE = 3'b111
  } cpc_sel_e;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } cpc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cpc_axi_rsp_s;

  typedef struct packed {
    logic tx_fs;
    logic tx_fs_rise;
    logic tx_fs_fall;
    logic tx_bclk_rise;
    logic tx_bclk_fall;
    logic rx_fs;
    logic rx_fs_fall;
    logic rx_bclk_rise;
    logic rx_bclk_fall;
    logic data_in;
  } cpc_pins_s;

  typedef struct packed {
    logic analog_oe;
    logic filter_bypass;
    logic [2:0] rx_trim_atten;
    logic [2:0] tx_trim_gain;
    logic pa_enable;
    logic aux_enable;
    logic [2:0] sidetone_code;
    logic a_law;
    logic charge_pump_en;
    logic analog_loopback;
    logic [1:0] io_mode;
    logic direct_seq_clk;
    logic [7:0] tone_setting_a;
    logic [7:0] tone_setting_b;
    logic tone_rate_delay;
    logic tone_active;
    logic decoder_enable;
    logic tone_to_rx_gain;
    logic tone_to_encoder;
    logic coder_reset;
    logic conv_strobe;
  } cpc_ctrl_s;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
  } cpc_sync_st_s;

  typedef struct packed {
    logic [15:0] period;
    logic [10:0] ratio;
    logic [10:0] div;
    logic locked;
    logic tick;
  } cpc_psc_st_s;

  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] main_reg;
    logic [7:0] txg_reg;
    logic [7:0] rxp_reg;
    logic [7:0] tonea_reg;
    logic [7:0] toneb_reg;
    logic [7:0] toned_reg;
    cpc_pwr_e pwr;
    logic [1:0] fs_seen;
    logic pin_q;
    logic coder_rst;
    logic [3:0] tx_falls;
    cpc_rate_e tx_rate;
    logic long_mode;
    logic dt_oe;
    logic dt_bit;
    logic [7:0] tx_sh;
    logic [3:0] tx_sent;
    logic [3:0] rx_cnt;
    logic [7:0] rx_sh;
    logic [7:0] rx_word;
    cpc_rate_e rx_rate;
    logic rx_valid;
  } cpc_top_st_s;

endpackage : cpc_pkg

// >>> hw/cpc_pin_sync.sv
`include "cpc_regs.svh"

module cpc_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_frame_sync,
  input wire logic tx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic rx_bit_clock,
  input wire logic serial_data_in,
  output cpc_pkg::cpc_pins_s pins
);

  cpc_pkg::cpc_sync_st_s st_ff;
  cpc_pkg::cpc_sync_st_s nxt_st;
  logic [4:0] raw;

  assign raw = {serial_data_in, rx_bit_clock, rx_frame_sync, tx_bit_clock,
                tx_frame_sync};

  // two-flop synchroniser, third flop only for edge detection
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (!aresetn) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  always_comb begin
    pins.tx_fs = st_ff.s2[`CPC_PIN_TXFS];
    pins.tx_fs_rise = st_ff.s2[`CPC_PIN_TXFS] & ~st_ff.s3[`CPC_PIN_TXFS];
    pins.tx_fs_fall = ~st_ff.s2[`CPC_PIN_TXFS] & st_ff.s3[`CPC_PIN_TXFS];
    pins.tx_bclk_rise = st_ff.s2[`CPC_PIN_TXCK] & ~st_ff.s3[`CPC_PIN_TXCK];
    pins.tx_bclk_fall = ~st_ff.s2[`CPC_PIN_TXCK] & st_ff.s3[`CPC_PIN_TXCK];
    pins.rx_fs = st_ff.s2[`CPC_PIN_RXFS];
    pins.rx_fs_fall = ~st_ff.s2[`CPC_PIN_RXFS] & st_ff.s3[`CPC_PIN_RXFS];
    pins.rx_bclk_rise = st_ff.s2[`CPC_PIN_RXCK] & ~st_ff.s3[`CPC_PIN_RXCK];
    pins.rx_bclk_fall = ~st_ff.s2[`CPC_PIN_RXCK] & st_ff.s3[`CPC_PIN_RXCK];
    pins.data_in = st_ff.s2[`CPC_PIN_DIN];
  end

endmodule : cpc_pin_sync

// >>> hw/cpc_prescaler.sv
`include "cpc_regs.svh"

module cpc_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic direct_sel,
  input wire logic fs_rise,
  input wire logic rx_bclk_rise,
  output logic seq_tick,
  output logic locked
);

  cpc_pkg::cpc_psc_st_s st_ff;
  cpc_pkg::cpc_psc_st_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'h0;
    if (!enable) begin
      nxt_st = '0;
    end else if (direct_sel) begin
      nxt_st.tick = rx_bclk_rise;
      nxt_st.locked = 1'h1;
    end else begin
      if (st_ff.period != `CPC_PER_MAX) begin
        nxt_st.period = st_ff.period + 16'h1;
      end
      // frame period divided by 32 gives the divide ratio, phase reset at fs
      if (fs_rise) begin
        nxt_st.period = 16'h0;
        nxt_st.ratio = st_ff.period[15:`CPC_PER_SHIFT];
        nxt_st.locked = st_ff.period != `CPC_PER_MAX;
        nxt_st.div = 11'h0;
        nxt_st.tick = 1'h1;
      end else if (st_ff.locked) begin
        if (st_ff.div + 11'h1 >= st_ff.ratio) begin
          nxt_st.div = 11'h0;
          nxt_st.tick = 1'h1;
        end else begin
          nxt_st.div = st_ff.div + 11'h1;
        end
      end
    end
    if (!aresetn) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  assign seq_tick = st_ff.tick;
  assign locked = st_ff.locked;

endmodule : cpc_prescaler

// >>> tb/cpc_codec_ctrl_assertions.sv
module cpc_codec_ctrl_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic powerdown_reset_n,
  input wire logic tx_frame_sync,
  input wire logic serial_data_out_oe,
  input wire logic control_port_tx_oe,
  input wire logic rx_word_valid,
  input wire cpc_pkg::cpc_rate_e tx_rate,
  input wire cpc_pkg::cpc_ctrl_s ctrl
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pin_dout_off: assert property (
    !powerdown_reset_n |=> !serial_data_out_oe) else $error("dout on");
  a_pin_ctl_off: assert property (
    !powerdown_reset_n |-> !control_port_tx_oe) else $error("ctl on");
  a_coder_reset: assert property (
    $rose(powerdown_reset_n) |=> ctrl.coder_reset) else $error("no rst");
  a_tone_decoder: assert property (
    ctrl.tone_active |-> !ctrl.decoder_enable) else $error("decoder on");
  a_tone_route: assert property (
    ctrl.tone_active |-> ctrl.tone_to_rx_gain) else $error("tone route");
  a_tone_rate: assert property (
    ctrl.tone_active |-> tx_rate != cpc_pkg::RATE_64K ||
    ctrl.analog_loopback) else $error("tone at 64k");
  a_dout_start: assert property (
    $rose(serial_data_out_oe) |-> tx_frame_sync) else $error("oe early");
  a_dout_hold: assert property (
    serial_data_out_oe && tx_frame_sync && powerdown_reset_n
    |=> serial_data_out_oe) else $error("oe dropped");
  a_rx_pulse: assert property (
    rx_word_valid |=> !rx_word_valid) else $error("valid long");
endmodule : cpc_codec_ctrl_checker

// >>> tb/cpc_highway_model.sv
module cpc_highway_model (
  input wire logic aclk,
  output logic tx_frame_sync,
  output logic tx_bit_clock,
  output logic rx_frame_sync,
  output logic rx_bit_clock,
  output logic serial_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ck = 0, fs = 0, d = 0;
  assign tx_frame_sync = fs;
  assign rx_frame_sync = fs;
  assign tx_bit_clock = ck;
  assign rx_bit_clock = ck;
  assign serial_data_in = d;
  // bit clock stands still low between frames
  task automatic frame(input int len, input logic [7:0] w);
    fs <= 1;
    ck <= 1;
    d <= w[7];
    for (int i = 0; i < len; i++) begin
      repeat (4) @(posedge aclk);
      ck <= 0;
      repeat (4) @(posedge aclk);
      if (i < len - 1) begin
        ck <= 1;
        d <= w[6-i];
      end
    end
    fs <= 0;
    d <= ~d;
    repeat (16) @(posedge aclk);
  endtask : frame
endmodule : cpc_highway_model

// >>> tb/test_codec_power_clock_framing_control.sv
module test_codec_power_clock_framing_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, powerdown_reset_n = 1, oe_hit = 0, oe_q = 0;
  cpc_pkg::cpc_axi_req_s s_axi_req = '0;
  cpc_pkg::cpc_axi_rsp_s s_axi_rsp;
  cpc_pkg::cpc_ctrl_s ctrl;
  cpc_pkg::cpc_rate_e rx_rate, tx_rate;
  logic tx_frame_sync, tx_bit_clock, rx_frame_sync, rx_bit_clock;
  logic serial_data_in, serial_data_out, serial_data_out_oe;
  logic control_port_tx_oe, rx_word_valid, seq_clk_tick;
  logic [7:0] tx_word = '0, rx_word;
  logic [33:0] rdq[$], x;
  logic [17:0] rxq[$], y;
  logic [31:0] v;
  int n_mismatch = 0, comparisons = 0, cyc = 0, nt = 0;
  int lens[4] = '{2, 3, 4, 8};
  always #5 aclk = ~aclk;
  cpc_codec_ctrl cpc_codec_ctrl_i (.aclk, .aresetn, .s_axi_req, .s_axi_rsp,
    .powerdown_reset_n, .tx_frame_sync, .tx_bit_clock, .rx_frame_sync,
    .rx_bit_clock, .serial_data_in, .tx_word, .serial_data_out,
    .serial_data_out_oe, .control_port_tx_oe, .rx_word, .rx_word_valid,
    .rx_rate, .tx_rate, .seq_clk_tick, .ctrl);
  cpc_highway_model cpc_highway_model_i (.aclk, .tx_frame_sync,
    .tx_bit_clock, .rx_frame_sync, .rx_bit_clock, .serial_data_in);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_req.awvalid <= 1;
    s_axi_req.awaddr <= a;
    s_axi_req.wvalid <= 1;
    s_axi_req.wdata <= d;
    s_axi_req.wstrb <= 4'hf;
    s_axi_req.bready <= 1;
    @(posedge aclk);
    while (s_axi_req.awvalid || s_axi_req.wvalid) begin
      if (s_axi_rsp.awready) s_axi_req.awvalid <= 0;
      if (s_axi_rsp.wready) s_axi_req.wvalid <= 0;
      @(posedge aclk);
    end
    // bready stays up between writes
    while (s_axi_rsp.bvalid !== 1'b1) @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    s_axi_req.arvalid <= 1;
    s_axi_req.araddr <= a;
    s_axi_req.rready <= 1;
    rdq.push_back({r, e});
    do @(posedge aclk); while (s_axi_rsp.arready !== 1'b1);
    s_axi_req.arvalid <= 0;
    // rready stays up between reads
    while (s_axi_rsp.rvalid !== 1'b1) @(posedge aclk);
  endtask : rd
  task automatic fr(input int l, input logic [1:0] rt, input bit push);
    logic [7:0] w;
    w = 8'($urandom);
    tx_word <= 8'($urandom);
    oe_hit = 0;
    if (push) rxq.push_back({rt, 8'((1 << l) - 1), 8'(w >> (8 - l))});
    cpc_highway_model_i.frame(l, w);
  endtask : fr
  always @(posedge aclk) begin
    cyc++;
    if (seq_clk_tick) nt++;
    if (serial_data_out_oe) oe_hit = 1;
    oe_q <= serial_data_out_oe;
    if (serial_data_out_oe && !oe_q) chk(serial_data_out, tx_word[7]);
    if (s_axi_rsp.rvalid && s_axi_req.rready) begin
      x = rdq.pop_front();
      chk(s_axi_rsp.rdata, x[31:0]);
      chk(s_axi_rsp.rresp, x[33:32]);
    end
    if (rx_word_valid && rxq.size() > 0) begin
      y = rxq.pop_front();
      chk(rx_word & y[15:8], y[7:0]);
      chk(rx_rate, y[17:16]);
    end
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h3593269d));
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(8'h04, 32'h70, 2'h0);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    chk(ctrl.charge_pump_en, 1);
    chk(ctrl.decoder_enable, 1);
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      fr(lens[k%4], 2'(k % 4), k >= 2);
      chk(oe_hit, k >= 2);
      if (k >= 2) chk(tx_rate, k % 4);
    end
    fr(1, 2'h0, 0);
    fr(4, 2'h2, 1);
    chk(oe_hit, 0);
    fr(4, 2'h2, 1);
    chk(oe_hit, 1);
    $display("test highway done");
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      wr(8'h08, {25'h0, v[6:3], i[2:0]});
      rd(8'h08, {25'h0, v[6:3], i[2:0]}, 2'h0);
      chk(ctrl.rx_trim_atten, i);
      chk(ctrl.filter_bypass, v[4]);
      chk(ctrl.pa_enable, !v[5]);
      chk(ctrl.aux_enable, !v[6]);
      wr(8'h04, {25'h0, i[2:0], 1'b0, v[2:0]});
      chk(ctrl.sidetone_code, i);
    end
    $display("test analog controls done");
    fr(8, 2'h3, 1);
    wr(8'h1c, 32'h1);
    chk(ctrl.tone_active, 0);
    wr(8'h00, 32'h24);
    chk(ctrl.tone_active, 1);
    chk(ctrl.decoder_enable, 0);
    chk(ctrl.tone_to_rx_gain, 1);
    chk(ctrl.a_law, 1);
    wr(8'h1c, 32'h3);
    chk(ctrl.tone_to_encoder, 1);
    $display("test tone done");
    wr(8'h00, 32'h1);
    chk(ctrl.analog_oe, 0);
    chk(control_port_tx_oe, 1);
    wr(8'h00, 32'h2);
    chk(control_port_tx_oe, 0);
    powerdown_reset_n <= 0;
    repeat (3) @(posedge aclk);
    chk(serial_data_out_oe, 0);
    chk(ctrl.analog_oe, 0);
    powerdown_reset_n <= 1;
    repeat (3) @(posedge aclk);
    rd(8'h08, 32'h0, 2'h0);
    rd(8'h00, 32'h0, 2'h0);
    $display("test power done");
    wr(8'h00, 32'h80);
    @(posedge aclk);
    nt = 0;
    fr(4, 2'h2, 1);
    chk(ctrl.direct_seq_clk, 1);
    chk(nt, 4);
    $display("test direct clock done");
    complete_run();
  end
endmodule : test_codec_power_clock_framing_control

bind cpc_codec_ctrl cpc_codec_ctrl_checker cpc_codec_ctrl_checker_i (
  .aclk, .aresetn, .powerdown_reset_n, .tx_frame_sync, .serial_data_out_oe,
  .control_port_tx_oe, .rx_word_valid, .tx_rate, .ctrl);
